/* File: prog_cell_defs.svh */
`ifndef PROG_CELL_DEFS_SVH
`define PROG_CELL_DEFS_SVH

// Register byte offsets on the bus
`define OFS_ACC0   8'h00
`define OFS_ACC1   8'h04
`define OFS_DAT0   8'h08
`define OFS_DAT1   8'h0c
`define OFS_FIFO0  8'h10
`define OFS_FIFO1  8'h14
`define OFS_DPCFG  8'h18
`define OFS_MASKS  8'h1c
`define OFS_OUTSEL 8'h20
`define OFS_CTRL   8'h24
`define OFS_STATUS 8'h28
`define OFS_STICKY 8'h2c
`define OFS_FSTAT  8'h30
// Configuration words occupy 0x40..0x5c
`define CFGRAM_HI  3'h2

// Datapath setup register fields
`define DPC_DIR0   0
`define DPC_MSB_LO 2
`define DPC_CHAIN  5
`define DPC_SIN_LO 6
`define DPC_CMP_LO 8
`define DPC_DP_RUN 10
`define DPC_SC_RUN 11

// Reset values
`define DPCFG_RST  12'hc1c
`define OUTSEL_RST 24'h54_3210

// Codes inside a configuration word, and the output select code for the zero flag of the first accumulator
`define DEST_A0    2'h1
`define DEST_A1    2'h2
`define LD_D       2'h1
`define LD_A0      2'h2
`define LD_A1      2'h3
`define COND_Z0    4'h4

`endif

/* File: prog_cell_pkg.sv */
package prog_cell_pkg;

    // ALU operations
    typedef enum logic [2:0] {
        OP_PASS, OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR
    } alu_op_t;

    // Post-ALU shifter operations
    typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} shift_op_t;

    // One dynamic configuration word
    typedef struct packed {
        logic      fifoCap;
        logic      crcEn;
        logic      orMaskEn;
        logic [1:0] fifoLoad;
        logic [1:0] dest;
        logic      carrySel;
        shift_op_t shift;
        logic [1:0] srcB;
        logic      srcA;
        alu_op_t   op;
    } dp_cfg_t;

    // Classic Wishbone request and answer
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Signals exchanged with a neighbouring datapath
    typedef struct packed {
        logic carry;
        logic shiftData;
        logic eq;
        logic lt;
    } chain_t;

    // Datapath state
    typedef struct packed {
        logic [7:0]       a0;
        logic [7:0]       a1;
        logic [7:0]       d0;
        logic [7:0]       d1;
        logic             carry;
        logic             shOut;
        logic [7:0][15:0] cfgRam;
        logic [11:0]      dpCfg;
        logic [15:0]      masks;
        logic [23:0]      outSel;
        logic [5:0]       routeOut;
        logic             ack;
        logic [31:0]      rdat;
    } dp_state_t;

    // Status and control state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mask;
        logic [7:0] sticky;
    } sc_state_t;

endpackage

/* File: cell_fifo.sv */
`timescale 1ns/1ps
module cell_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  logic         ref_clk,
    input  logic         resetn,
    input  logic         pushValid,
    input  logic [W-1:0] pushData,
    output logic         pushReady,
    output logic         popValid,
    input  logic         popReady,
    output logic [W-1:0] popData
);
    import prog_cell_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [CW-1:0]           cnt;
    } fifo_state_t;

    fifo_state_t q, d;   // Storage, pointers and fill level
    logic push, pop;     // Accepted transfers

    assign push      = pushValid && pushReady;
    assign pop       = popValid && popReady;
    assign pushReady = q.cnt != CW'(DEPTH);
    assign popValid  = q.cnt != '0;
    assign popData   = q.mem[q.rd];

    // Pointers wrap explicitly so any depth works
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wr] = pushData;
            d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
        end
        if (pop)
            d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
        d.cnt = q.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= d;
    end

    // A push that takes the last free slot, with no pop beside it, fills the buffer
    sequence s_fill;
        push && !pop && q.cnt == CW'(DEPTH - 1);
    endsequence
    a_fifo_fill: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_fill |=> !pushReady)
        else $error("buffer not full after last free slot taken");
endmodule

/* File: status_control_unit.sv */
`timescale 1ns/1ps
module status_control_unit (
    input  logic       ref_clk,
    input  logic       resetn,
    input  logic       run,
    input  logic       wrCtrl,
    input  logic       wrSticky,
    input  logic       rdStatus,
    input  logic [7:0] wrData,
    input  logic [7:0] clrBits,
    input  logic [7:0] statusIn,
    output logic [7:0] ctrlOut,
    output logic [7:0] statusVal,
    output logic [7:0] stickyMask
);
    import prog_cell_pkg::*;

    sc_state_t q, d;   // Control bits, sticky selection, latched events

    // Clear before set, so an event in the read cycle is kept
    always_comb
    begin
        d = q;
        if (wrCtrl)
            d.ctrl = wrData;
        if (wrSticky)
            d.mask = wrData;
        if (rdStatus)
            d.sticky = q.sticky & ~clrBits;
        if (run)
            d.sticky = d.sticky | (statusIn & q.mask);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= d;
    end

    // Sticky bits show the latch, others the live routing signal
    assign statusVal  = (q.sticky & q.mask) | (statusIn & ~q.mask);
    assign ctrlOut    = q.ctrl;
    assign stickyMask = q.mask;

    a_sticky_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
        q.sticky[0] && !(rdStatus && clrBits[0]) |=> q.sticky[0])
        else $error("sticky bit lost without a read");
    a_sticky_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        rdStatus && clrBits[0] && !(run && statusIn[0] && q.mask[0])
        |=> !q.sticky[0])
        else $error("sticky bit not cleared by read");
endmodule

/* File: programmable_cell_datapath.sv */
`timescale 1ns/1ps
`include "prog_cell_defs.svh"
module programmable_cell_datapath (
    input  logic                     ref_clk,
    input  logic                     resetn,
    input  prog_cell_pkg::wb_req_t   wbReq,
    output prog_cell_pkg::wb_rsp_t   wbRsp,
    input  logic [5:0]               routeIn,
    output logic [5:0]               routeOut,
    input  prog_cell_pkg::chain_t    chainIn,
    output prog_cell_pkg::chain_t    chainOut,
    input  logic [7:0]               statusIn,
    output logic [7:0]               ctrlOut
);
    import prog_cell_pkg::*;

    dp_state_t  q, d;          // All registered state
    dp_cfg_t    cfg;           // Word selected this cycle
    logic [7:0] opA, opB;      // ALU operands
    logic [8:0] sum;           // ALU result with carry
    logic [7:0] wMask;         // Bits at or below the MSB
    logic [7:0] aluRaw;        // Masked ALU result
    logic [7:0] shRes;         // After shifter or CRC step
    logic [7:0] result;        // After OR mask
    logic       cin, cout;     // Carry in and out
    logic       sin, so;       // Serial in and out
    logic       ov, fb;        // Overflow, CRC feedback
    logic [2:0] msb;           // Programmed MSB position
    logic       dpRun;         // Datapath runs this cycle
    logic       chainEn;       // Use neighbour compare results
    logic [7:0] cm, c1a, c1b;  // Compare mask and operands
    logic       eqR0, ltR0;    // Local compare 0
    logic       eqR1, ltR1;    // Compare 1
    logic       eq0, lt0;      // Compare 0 after chaining
    logic [15:0] cond;         // All selectable conditions
    logic [5:0]  outMux;       // Selected outputs
    logic        busHit;       // New request seen
    logic        busWr, busRd; // Transfer completes now
    logic [31:0] rdMux;        // Current register contents
    logic [31:0] wd;           // Write data merged by lanes
    logic [1:0]  fDir;         // 1: FIFO is an output buffer
    logic [1:0]  fStrobe;      // Routing FIFO strobes
    logic [1:0]  fPushV, fPushR, fPopV, fPopR;
    logic [1:0][7:0] fPushD, fPopD;
    logic [1:0]  busWrF, busRdF; // Bus FIFO accesses
    logic [1:0]  ldUse;        // Word asks to load from FIFO
    logic [1:0]  ldGo;         // A load really happens
    logic [7:0]  statusVal;    // Status register value
    logic [7:0]  stickyMask;   // Which status bits latch

    // Byte-lane merge of write data into the current value
    function automatic logic [31:0] laneMerge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0]  sel
    );
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++)
            m[8*b +: 8] = sel[b] ? wdat[8*b +: 8] : old[8*b +: 8];
        return m;
    endfunction

    // Setup fields
    assign msb     = q.dpCfg[`DPC_MSB_LO +: 3];
    assign dpRun   = q.dpCfg[`DPC_DP_RUN];
    assign chainEn = q.dpCfg[`DPC_CHAIN];
    assign fDir    = q.dpCfg[`DPC_DIR0 +: 2];

    // Routing inputs: word address, serial in, FIFO strobes
    assign cfg     = dp_cfg_t'(q.cfgRam[routeIn[2:0]]);
    assign fStrobe = routeIn[5:4];

    // Bus phases: request seen, then completion at the ack edge
    assign busHit = wbReq.cyc && wbReq.stb && !q.ack;
    assign busWr  = wbReq.cyc && wbReq.stb && wbReq.we && q.ack;
    assign busRd  = wbReq.cyc && wbReq.stb && !wbReq.we && q.ack;
    assign busWrF = {busWr && wbReq.adr == `OFS_FIFO1,
                     busWr && wbReq.adr == `OFS_FIFO0} & {2{wbReq.sel[0]}};
    assign busRdF = {busRd && wbReq.adr == `OFS_FIFO1,
                     busRd && wbReq.adr == `OFS_FIFO0};

    // FIFO load requests from the word
    assign ldUse[0] = cfg.fifoLoad == `LD_D || cfg.fifoLoad == `LD_A0;
    assign ldUse[1] = cfg.fifoLoad == `LD_D || cfg.fifoLoad == `LD_A1;

    // ALU, variable MSB, shifter, CRC and mask
    always_comb
    begin
        opA = cfg.srcA ? q.a1 : q.a0;
        case (cfg.srcB)
            2'h0:    opB = q.d0;
            2'h1:    opB = q.d1;
            2'h2:    opB = q.a0;
            default: opB = q.a1;
        endcase
        // Registered carry lets one datapath do 16-bit work
        cin = cfg.carrySel ? q.carry : chainIn.carry;
        for (int k = 0; k < 8; k++)
            wMask[k] = (k <= int'(msb));
        case (cfg.op)
            OP_INC:  sum = {1'b0, opA} + 9'h001;
            OP_DEC:  sum = {1'b0, opA} - 9'h001;
            OP_ADD:  sum = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
            OP_SUB:  sum = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
            OP_AND:  sum = {1'b0, opA & opB};
            OP_OR:   sum = {1'b0, opA | opB};
            OP_XOR:  sum = {1'b0, opA ^ opB};
            default: sum = {1'b0, opA};
        endcase
        // Carry is taken just above the programmed MSB
        aluRaw = sum[7:0] & wMask;
        cout   = sum[{1'b0, msb} + 4'h1];
        ov     = (cfg.op == OP_ADD || cfg.op == OP_SUB)
              && (opA[msb] != aluRaw[msb])
              && ((opA[msb] != opB[msb]) == (cfg.op == OP_SUB));
        // Serial input source
        case (q.dpCfg[`DPC_SIN_LO +: 2])
            2'h0:    sin = routeIn[3];
            2'h1:    sin = chainIn.shiftData;
            2'h2:    sin = q.shOut;
            default: sin = 1'b0;
        endcase
        fb    = opA[msb] ^ sin;
        shRes = aluRaw;
        so    = 1'b0;
        if (cfg.crcEn)
        begin
            // One step per clock; polynomial sits in the first data register
            shRes = ({opA[6:0], 1'b0} ^ (fb ? q.d0 : 8'h00)) & wMask;
            so    = opA[msb];
        end
        else
        begin
            case (cfg.shift)
                SH_LEFT:
                begin
                    shRes = {aluRaw[6:0], sin} & wMask;
                    so    = aluRaw[msb];
                end
                SH_RIGHT:
                begin
                    shRes      = aluRaw >> 1;
                    shRes[msb] = sin;
                    so         = aluRaw[0];
                end
                SH_SWAP: shRes = {aluRaw[3:0], aluRaw[7:4]};
                default: shRes = aluRaw;
            endcase
        end
        result = cfg.orMaskEn ? (shRes | q.masks[7:0]) : shRes;
    end

    // Two masked comparators and the condition vector
    always_comb
    begin
        cm = q.masks[15:8];
        case (q.dpCfg[`DPC_CMP_LO +: 2])
            2'h0:    {c1a, c1b} = {q.a1, q.d1};
            2'h1:    {c1a, c1b} = {q.a0, q.d1};
            2'h2:    {c1a, c1b} = {q.a1, q.a0};
            default: {c1a, c1b} = {q.a1, q.d0};
        endcase
        eqR0 = (q.a0 & cm) == (q.d0 & cm);
        ltR0 = (q.a0 & cm) < (q.d0 & cm);
        eqR1 = (c1a & cm) == (c1b & cm);
        ltR1 = (c1a & cm) < (c1b & cm);
        // Chain input comes from the lower-order neighbour
        eq0  = eqR0 && (!chainEn || chainIn.eq);
        lt0  = ltR0 || (chainEn && eqR0 && chainIn.lt);
        cond = {q.carry, !fPushR[1], !fPopV[1], !fPushR[0], !fPopV[0],
                so, cout, ov, &q.a1, &q.a0,
                q.a1 == 8'h00, q.a0 == 8'h00, ltR1, eqR1, lt0, eq0};
    end

    assign chainOut = {cout, so, eq0, lt0};

    // Each routing output picks one condition
    for (genvar i = 0; i < 6; i++)
    begin : g_out
        assign outMux[i] = cond[q.outSel[4*i +: 4]];
    end

    // Two FIFOs, each an input or output buffer
    for (genvar i = 0; i < 2; i++)
    begin : g_fifo
        // Output buffer takes the result on its routing strobe
        assign fPushV[i] = fDir[i] ? (dpRun && cfg.fifoCap && fStrobe[i])
                                   : busWrF[i];
        assign fPushD[i] = fDir[i] ? result : wbReq.dat[7:0];
        assign fPopR[i]  = fDir[i] ? busRdF[i]
                                   : (dpRun && ldUse[i] && fStrobe[i]);
        assign ldGo[i]   = !fDir[i] && fPopR[i] && fPopV[i];
        cell_fifo #(
            .W     (8),
            .DEPTH (4)
        ) u_fifo (
            .ref_clk   (ref_clk),
            .resetn    (resetn),
            .pushValid (fPushV[i]),
            .pushData  (fPushD[i]),
            .pushReady (fPushR[i]),
            .popValid  (fPopV[i]),
            .popReady  (fPopR[i]),
            .popData   (fPopD[i])
        );
    end

    // Current contents at the addressed offset
    always_comb
    begin
        case (wbReq.adr)
            `OFS_ACC0:   rdMux = {24'h00_0000, q.a0};
            `OFS_ACC1:   rdMux = {24'h00_0000, q.a1};
            `OFS_DAT0:   rdMux = {24'h00_0000, q.d0};
            `OFS_DAT1:   rdMux = {24'h00_0000, q.d1};
            `OFS_FIFO0:  rdMux = {24'h00_0000, fPopV[0] ? fPopD[0] : 8'h00};
            `OFS_FIFO1:  rdMux = {24'h00_0000, fPopV[1] ? fPopD[1] : 8'h00};
            `OFS_DPCFG:  rdMux = {20'h0_0000, q.dpCfg};
            `OFS_MASKS:  rdMux = {16'h0000, q.masks};
            `OFS_OUTSEL: rdMux = {8'h00, q.outSel};
            `OFS_CTRL:   rdMux = {24'h00_0000, ctrlOut};
            `OFS_STATUS: rdMux = {24'h00_0000, statusVal};
            `OFS_STICKY: rdMux = {24'h00_0000, stickyMask};
            `OFS_FSTAT:  rdMux = {26'h000_0000, q.shOut, q.carry, fPushR, fPopV};
            default:
                rdMux = (wbReq.adr[7:5] == `CFGRAM_HI)
                      ? {16'h0000, q.cfgRam[wbReq.adr[4:2]]}
                      : 32'h0000_0000;
        endcase
        wd = laneMerge(rdMux, wbReq.dat, wbReq.sel);
    end

    // Next state: datapath step, FIFO loads, then bus writes
    always_comb
    begin
        d          = q;
        d.ack      = 1'b0;
        d.routeOut = outMux;
        if (dpRun)
        begin
            d.carry = cout;
            d.shOut = so;
            case (cfg.dest)
                `DEST_A0: d.a0 = result;
                `DEST_A1: d.a1 = result;
                default:  d.a0 = q.a0;
            endcase
        end
        // A FIFO load wins over the ALU for the same register
        if (ldGo[0] && cfg.fifoLoad == `LD_D)
            d.d0 = fPopD[0];
        else if (ldGo[0])
            d.a0 = fPopD[0];
        if (ldGo[1] && cfg.fifoLoad == `LD_D)
            d.d1 = fPopD[1];
        else if (ldGo[1])
            d.a1 = fPopD[1];
        // Answer one cycle after the request, data from the flop
        if (busHit)
        begin
            d.ack  = 1'b1;
            d.rdat = rdMux;
        end
        // Firmware writes take priority over the datapath
        if (busWr)
        begin
            case (wbReq.adr)
                `OFS_ACC0:   d.a0 = wd[7:0];
                `OFS_ACC1:   d.a1 = wd[7:0];
                `OFS_DAT0:   d.d0 = wd[7:0];
                `OFS_DAT1:   d.d1 = wd[7:0];
                `OFS_DPCFG:  d.dpCfg = wd[11:0];
                `OFS_MASKS:  d.masks = wd[15:0];
                `OFS_OUTSEL: d.outSel = wd[23:0];
                default:
                    if (wbReq.adr[7:5] == `CFGRAM_HI)
                        d.cfgRam[wbReq.adr[4:2]] = wd[15:0];
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            q        <= '0;
            q.dpCfg  <= `DPCFG_RST;
            q.outSel <= `OUTSEL_RST;
        end
        else
            q <= d;
    end

    assign wbRsp    = {q.ack, q.rdat};
    assign routeOut = q.routeOut;

    // Status read clears exactly the sticky bits it returned
    status_control_unit u_stat (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .run        (q.dpCfg[`DPC_SC_RUN]),
        .wrCtrl     (busWr && wbReq.adr == `OFS_CTRL),
        .wrSticky   (busWr && wbReq.adr == `OFS_STICKY),
        .rdStatus   (busRd && wbReq.adr == `OFS_STATUS),
        .wrData     (wd[7:0]),
        .clrBits    (q.rdat[7:0]),
        .statusIn   (statusIn),
        .ctrlOut    (ctrlOut),
        .statusVal  (statusVal),
        .stickyMask (stickyMask)
    );

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_busReq;
        wbReq.cyc && wbReq.stb && !wbRsp.ack;
    endsequence
    sequence s_ctrlWr;
        busWr && wbReq.adr == `OFS_CTRL && wbReq.sel[0];
    endsequence

    a_bus_ack: assert property (s_busReq |=> wbRsp.ack ##1 !wbRsp.ack)
        else $error("bus answer not a single cycle");
    a_ctrl_write: assert property (s_ctrlWr |=> ctrlOut == $past(wbReq.dat[7:0]))
        else $error("control write not seen on routing");
    a_acc_dest: assert property (dpRun && cfg.dest == `DEST_A1 && !ldGo[1]
        && !(busWr && wbReq.adr == `OFS_ACC1) |=> q.a1 == $past(result))
        else $error("result not in selected accumulator");
    a_acc_keep: assert property ((!dpRun || cfg.dest != `DEST_A0) && !ldGo[0]
        && !(busWr && wbReq.adr == `OFS_ACC0) |=> $stable(q.a0))
        else $error("unselected accumulator changed");
    a_data_src: assert property (!ldGo[0]
        && !(busWr && wbReq.adr == `OFS_DAT0) |=> $stable(q.d0))
        else $error("data register took an ALU result");
    a_carry_reg: assert property (dpRun |=> q.carry == $past(cout))
        else $error("carry not registered");
    a_zero_out: assert property ((resetn && q.outSel[19:16] == `COND_Z0) [*2]
        |-> routeOut[4] == ($past(q.a0) == 8'h00))
        else $error("zero detect not routed");
endmodule

/* File: route_model.sv */
`timescale 1ns/1ps
// Stand-in for the routing matrix and the lower-order neighbour cell
module route_model (
    input  wire logic             ref_clk,
    input  wire logic [2:0]       wordSel,
    input  wire logic [1:0]       strobe,
    input  wire logic [7:0]       statusSet,
    output logic [5:0]            routeIn,
    output prog_cell_pkg::chain_t chainIn,
    output logic [7:0]            statusIn
);
    import prog_cell_pkg::*;
    logic serialBit = 1'b0; // Toggles so nothing leans on a settled level
    // Serial line keeps moving every cycle
    always @(posedge ref_clk)
        serialBit <= ~serialBit;
    // Word index, serial bit and FIFO strobes in routing order
    assign routeIn = {strobe, serialBit, wordSel};
    // Neighbour offers no carry, so sums depend on the cell alone
    assign chainIn = '{carry: 1'b0, shiftData: serialBit, eq: 1'b1, lt: 1'b0};
    // Status sources are plain routing levels
    assign statusIn = statusSet;
endmodule

/* File: test_programmable_cell_datapath.sv */
`timescale 1ns/1ps
module test_programmable_cell_datapath;
    import prog_cell_pkg::*;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    wb_req_t    wbReq = '0;
    wb_rsp_t    wbRsp;
    logic [5:0] routeIn;
    logic [5:0] routeOut;
    chain_t     chainIn;
    chain_t     chainOut;
    logic [7:0] statusIn;
    logic [7:0] ctrlOut;
    logic [7:0] statusSet = 8'h00; // Levels handed to the routing model
    logic [2:0] wordSel = 3'h0;    // Zero selects the idle word
    logic [1:0] strobe = 2'b00;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] d;
    logic [8:0] t [12];            // Expected carry and result of each step
    logic [15:0] w [4] = '{16'h04c0, 16'h0440, 16'h4400, 16'h2400}; // Swap, shift, CRC, mask
    logic [7:0] q [$];             // Bytes expected out of FIFO zero
    logic [31:0] r;                // Last read data
    int         fail_count = 0;
    int         checked = 0;

    always #12.5 ref_clk = ~ref_clk;

    programmable_cell_datapath dut (.ref_clk(ref_clk), .resetn(resetn), .wbReq(wbReq),
        .wbRsp(wbRsp), .routeIn(routeIn), .routeOut(routeOut), .chainIn(chainIn),
        .chainOut(chainOut), .statusIn(statusIn), .ctrlOut(ctrlOut));
    route_model peer (.ref_clk(ref_clk), .wordSel(wordSel), .strobe(strobe),
        .statusSet(statusSet), .routeIn(routeIn), .chainIn(chainIn), .statusIn(statusIn));

    // Verdict and end of run
    task automatic test_done();
        $display("Mismatches %0d of %0d comparisons", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Compare one result with the model
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic bus cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n = 0;
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (wbRsp.ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            fail_count++;
            $display("[FAIL] %0t no bus answer", $time);
            test_done();
        end
        r = wbRsp.dat;
        wbReq <= '0;
        @(posedge ref_clk);
    endtask

    initial
    begin
        void'($urandom(32'h536d));
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        wb(0, 8'h18, 0);
        check(r, 32'h0000_0c1c);
        wb(0, 8'h3c, 0);
        check(r, 32'h0000_0000);
        // Serial input tied low so shifts and sequence steps are predictable
        wb(1, 8'h18, 32'h0000_0cdc);
        // Every ALU operation, then swap, left shift, CRC and OR mask, result into the second accumulator
        for (int op = 0; op < 12; op++)
        begin
            a = $urandom;
            b = $urandom;
            d = $urandom;
            t = '{{1'b0, a}, {1'b0, a} + 9'h001, {1'b0, a} - 9'h001, {1'b0, a} + {1'b0, d},
                {1'b0, a} - {1'b0, d}, {1'b0, a & d}, {1'b0, a | d}, {1'b0, a ^ d},
                {1'b0, a[3:0], a[7:4]}, {1'b0, a[6:0], 1'b0},
                {1'b0, {a[6:0], 1'b0} ^ (a[7] ? d : 8'h00)}, {1'b0, a | b}};
            wb(1, 8'h00, 32'(a));
            wb(1, 8'h04, 32'(b));
            wb(1, 8'h08, 32'(d));
            wb(1, 8'h1c, 32'(b));
            wb(1, 8'h44, (op < 8) ? 32'(op) | 32'h0000_0400 : 32'(w[op - 8]));
            wordSel <= 3'h1;
            @(negedge ref_clk);
            check(32'(chainOut.carry), 32'(t[op][8]));
            @(posedge ref_clk);
            wordSel <= 3'h0;
            @(posedge ref_clk);
            wb(0, 8'h04, 0);
            check(r, 32'(t[op][7:0]));
            wb(0, 8'h00, 0);
            check(r, 32'(a));
        end
        a = $urandom;
        wb(1, 8'h24, 32'(a));
        check(32'(ctrlOut), 32'(a));
        // Bit 0 sticky, bit 1 live; a bus write to status is ignored
        wb(1, 8'h2c, 32'h0000_0001);
        statusSet <= 8'h03;
        @(posedge ref_clk);
        statusSet <= 8'h02;
        wb(0, 8'h28, 0);
        check(r, 32'h0000_0003);
        wb(1, 8'h28, 32'h0000_00ff);
        wb(0, 8'h28, 0);
        check(r, 32'h0000_0002);
        // Fifth byte into a full input FIFO is dropped
        for (int i = 0; i < 5; i++)
        begin
            a = $urandom;
            wb(1, 8'h10, 32'(a));
            if (i < 4)
                q.push_back(a);
        end
        wb(0, 8'h30, 0);
        check(r & 32'h0000_0005, 32'h0000_0001);
        wb(1, 8'h48, 32'h0000_1000);
        for (int i = 0; i < 4; i++)
        begin
            wordSel <= 3'h2;
            strobe <= 2'b01;
            @(posedge ref_clk);
            wordSel <= 3'h0;
            strobe <= 2'b00;
            @(posedge ref_clk);
            wb(0, 8'h00, 0);
            check(r, 32'(q.pop_front()));
        end
        wb(0, 8'h30, 0);
        check(r & 32'h0000_0005, 32'h0000_0004);
        // Output 4 follows the zero flag of the first accumulator
        for (int i = 0; i < 2; i++)
        begin
            wb(1, 8'h00, 32'(i));
            @(negedge ref_clk);
            check(32'(routeOut[4]), 32'(i == 0));
            @(posedge ref_clk);
        end
        test_done();
    end
endmodule
